// [logic/sacc_control.sv]
// conversion control and serial readout of the successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
module sacc_control (
    input  wire logic                       i_clock,           // system clock 40 MHz
    input  wire logic                       i_reset,           // synchronous, active high
    input  wire logic                       i_select_n,        // host select, active low
    input  wire logic                       i_serial_bit_clock,// host bit clock
    input  wire logic                       i_comp_high,       // comparator: trial below input
    input  wire logic                       i_over_range,      // input above reference span
    input  wire logic                       i_under_range,     // input below ground
    output logic                            o_positive_array_ground_switch, // closed when high
    output logic                            o_negative_array_ground_switch, // closed when high
    output logic                            o_arrays_on_inputs, // arrays tied to analog inputs
    output logic [sacc_pkg::SACC_BITS-1:0]  o_trial_bits,      // element at reference when high
    output logic                            o_powered,         // conversion core powered
    output logic                            o_busy,            // conversion in progress
    output logic [sacc_pkg::SACC_BITS-1:0]  o_result,          // last output code
    output logic                            o_data_out,        // serial data output value
    output logic                            o_data_oe          // serial data output enable
);
    import sacc_pkg::*;

    // ****************************************************************
    // pin synchronisers, three stages, change on agreement of 2 and 3
    // ****************************************************************
    logic [2:0] sel_sync_reg;
    logic [2:0] bck_sync_reg;
    logic       sel_reg;
    logic       bck_reg;
    logic       sel_next;
    logic       bck_next;

    assign sel_next = (sel_sync_reg[1] == sel_sync_reg[2]) ? sel_sync_reg[2] : sel_reg;
    assign bck_next = (bck_sync_reg[1] == bck_sync_reg[2]) ? bck_sync_reg[2] : bck_reg;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            sel_sync_reg <= 3'h7;
            bck_sync_reg <= 3'h0;
            sel_reg      <= 1'b1;
            bck_reg      <= 1'b0;
        end else begin
            sel_sync_reg <= {sel_sync_reg[1:0], i_select_n};
            bck_sync_reg <= {bck_sync_reg[1:0], i_serial_bit_clock};
            sel_reg      <= sel_next;
            bck_reg      <= bck_next;
        end
    end

    wire sel_fall = sel_reg & ~sel_next;
    wire bck_fall = bck_reg & ~bck_next;
    wire sel_low  = ~sel_reg;

    // ****************************************************************
    // conversion state machine
    // ****************************************************************
    sacc_state_t      state_reg;
    sacc_state_t      state_next;
    logic [4:0]       wait_reg;
    logic [3:0]       bit_reg;
    logic [15:0]      trial_reg;
    logic [15:0]      result_reg;

    wire wait_done = (wait_reg == SACC_SETTLE_CYCLES);
    wire last_bit  = (bit_reg == 4'h0);
    wire [15:0] one_hot  = 16'h0001 << bit_reg;
    wire [15:0] kept     = i_comp_high ? trial_reg : (trial_reg & ~one_hot);
    wire [15:0] stepped  = kept | (one_hot >> 1);
    // clamp on range flags instead of letting the search wrap
    wire [15:0] final_code = i_over_range  ? SACC_CODE_ONES :
                             i_under_range ? SACC_CODE_ZERO :
                             kept;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SACC_ACQUIRE: begin
                if (sel_fall) begin
                    state_next = SACC_OPEN_GND;
                end
            end
            SACC_OPEN_GND: begin
                if (wait_done) begin
                    state_next = SACC_MOVE_GND;
                end
            end
            SACC_MOVE_GND: begin
                if (wait_done) begin
                    state_next = SACC_SEARCH;
                end
            end
            SACC_SEARCH: begin
                if (last_bit) begin
                    state_next = SACC_FINISH;
                end
            end
            SACC_FINISH: begin
                state_next = SACC_ACQUIRE;
            end
            default: begin
                state_next = SACC_ACQUIRE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_reg  <= SACC_ACQUIRE;
            wait_reg   <= 5'h00;
            bit_reg    <= 4'hF;
            trial_reg  <= 16'h0000;
            result_reg <= SACC_CODE_ZERO;
        end else begin
            state_reg <= state_next;
            wait_reg  <= (state_next != state_reg) ? 5'h00 : wait_reg + 5'h01;
            if (state_reg == SACC_MOVE_GND) begin
                bit_reg   <= 4'hF;
                trial_reg <= 16'h8000;
            end else if (state_reg == SACC_SEARCH) begin
                bit_reg   <= bit_reg - 4'h1;
                trial_reg <= last_bit ? kept : stepped;
                if (last_bit) begin
                    result_reg <= final_code;
                end
            end else if (state_reg == SACC_ACQUIRE) begin
                trial_reg <= 16'h0000;
            end
        end
    end

    // ground switches closed only in acquisition; arrays on inputs in acquisition and in SACC_OPEN_GND, while the ground switches are opened
    assign o_positive_array_ground_switch = (state_reg == SACC_ACQUIRE);
    assign o_negative_array_ground_switch = (state_reg == SACC_ACQUIRE);
    assign o_arrays_on_inputs = (state_reg == SACC_ACQUIRE) ||
                                (state_reg == SACC_OPEN_GND);
    assign o_trial_bits = trial_reg;
    assign o_powered    = (state_reg != SACC_ACQUIRE);
    assign o_busy       = (state_reg != SACC_ACQUIRE);
    assign o_result     = result_reg;

    // ****************************************************************
    // serial readout
    // ****************************************************************
    logic [4:0]  fall_cnt_reg;
    logic [15:0] shift_reg;
    logic        dout_reg;
    logic        oe_reg;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            fall_cnt_reg <= 5'h00;
            shift_reg    <= 16'h0000;
            dout_reg     <= 1'b0;
            oe_reg       <= 1'b0;
        end else if (!sel_low) begin
            fall_cnt_reg <= 5'h00;
            dout_reg     <= 1'b0;
            oe_reg       <= 1'b0;
        end else if (bck_fall && fall_cnt_reg < SACC_LAST_FALL) begin
            fall_cnt_reg <= fall_cnt_reg + 5'h01;
            if (fall_cnt_reg + 5'h01 == {1'b0, SACC_LEAD_FALLS}) begin
                oe_reg    <= 1'b1;
                dout_reg  <= 1'b0;
                shift_reg <= result_reg;
            end else if (fall_cnt_reg >= {1'b0, SACC_LEAD_FALLS}) begin
                dout_reg  <= shift_reg[15];
                shift_reg <= {shift_reg[14:0], 1'b0};
            end
        end
    end

    assign o_data_out = dout_reg;
    assign o_data_oe  = oe_reg & sel_low;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_switch_order: assert property (@(posedge i_clock) disable iff (i_reset)
        sel_fall && state_reg == SACC_ACQUIRE |=> !o_positive_array_ground_switch && o_arrays_on_inputs)
        else $error("arrays left inputs before ground switches opened");
    a_oe_select: assert property (@(posedge i_clock) disable iff (i_reset)
        !sel_low |-> !o_data_oe)
        else $error("data output driven while select high");
    a_search_len: assert property (@(posedge i_clock) disable iff (i_reset)
        state_reg == SACC_MOVE_GND && state_next == SACC_SEARCH
        |=> (state_reg == SACC_SEARCH)[*8] ##1 (state_reg == SACC_SEARCH)[*8]
        ##1 state_reg == SACC_FINISH)
        else $error("search did not take sixteen steps");
    a_back_acquire: assert property (@(posedge i_clock) disable iff (i_reset)
        state_reg == SACC_FINISH |=> state_reg == SACC_ACQUIRE && o_positive_array_ground_switch)
        else $error("did not return to acquisition");
    a_clamp_high: assert property (@(posedge i_clock) disable iff (i_reset)
        state_reg == SACC_SEARCH && last_bit && i_over_range |=> o_result == SACC_CODE_ONES)
        else $error("overrange not clamped");
    a_clamp_low: assert property (@(posedge i_clock) disable iff (i_reset)
        state_reg == SACC_SEARCH && last_bit && !i_over_range && i_under_range |=> o_result == SACC_CODE_ZERO)
        else $error("underrange not clamped");
    a_lead_low: assert property (@(posedge i_clock) disable iff (i_reset)
        sel_low && bck_fall && fall_cnt_reg == 5'h04 |=> o_data_oe && !o_data_out)
        else $error("leading low bit missing");
    a_msb_first: assert property (@(posedge i_clock) disable iff (i_reset)
        sel_low && bck_fall && fall_cnt_reg == 5'h05 |=> o_data_out == $past(shift_reg[15]))
        else $error("data not shifted msb first");
    // sequencing of power, result, switch and readout phases
    a_power_down: assert property (@(posedge i_clock) disable iff (i_reset)
        state_reg == SACC_FINISH |=> !o_powered)
        else $error("core not powered down after conversion");
    a_result_hold: assert property (@(posedge i_clock) disable iff (i_reset)
        !(state_reg == SACC_SEARCH && last_bit) |=> $stable(o_result))
        else $error("result changed outside its own conversion end");
    a_shift_load: assert property (@(posedge i_clock) disable iff (i_reset)
        sel_low && bck_fall && fall_cnt_reg == 5'h04 |=> shift_reg == $past(o_result))
        else $error("readout not loaded from current result");
    a_acq_grounded: assert property (@(posedge i_clock) disable iff (i_reset)
        $fell(o_busy) |-> o_positive_array_ground_switch && o_negative_array_ground_switch
        && o_arrays_on_inputs)
        else $error("acquisition without grounded terminals");
    a_start_conv: assert property (@(posedge i_clock) disable iff (i_reset)
        sel_fall && !o_busy |=> o_busy && state_reg == SACC_OPEN_GND)
        else $error("select fall did not start a conversion");
    a_open_first: assert property (@(posedge i_clock) disable iff (i_reset)
        $fell(o_arrays_on_inputs) |-> !$past(o_positive_array_ground_switch)
        && !$past(o_negative_array_ground_switch))
        else $error("arrays moved before ground switches opened");
    a_oe_pin_high: assert property (@(posedge i_clock) disable iff (i_reset)
        sel_sync_reg[2] && sel_sync_reg[1] |=> !o_data_oe)
        else $error("data output enabled after select settled high");
    a_fall_limit: assert property (@(posedge i_clock) disable iff (i_reset)
        sel_low && fall_cnt_reg == SACC_LAST_FALL |=> $stable(o_data_out))
        else $error("data moved after the last result bit");
endmodule
`default_nettype wire

// [shared/sacc_pkg.sv]
// constants and types of the successive-approximation conversion control
//
// Behaviour
// - sustain up to 100 kSPS and power down between conversions
// - each result belongs to the conversion its own select fall started
// - during acquisition arrays sample inputs, comparator terminals grounded
// - host lowers select after acquisition; falling edge starts conversion
// - open ground switches first, then move arrays from inputs to ground
// - binary search over 16 bits, MSB first, one array element per step
// - after the search return to acquisition and form the output code
// - output code is straight unsigned binary
// - overrange input saturates at all ones
// - underrange input saturates at all zeros
// - select high holds serial data output in high impedance
// - after fifth bit clock fall the data output is enabled and low
// - then result shifts out MSB first, one bit per bit clock fall
package sacc_pkg;
    // ****************************************************************
    // sizes and codes
    // ****************************************************************
    localparam int          SACC_BITS      = 16;
    localparam logic [15:0] SACC_CODE_ZERO = 16'h0000;
    localparam logic [15:0] SACC_CODE_ONES = 16'hFFFF;
    localparam logic [3:0]  SACC_LEAD_FALLS = 4'h5;
    localparam logic [4:0]  SACC_LAST_FALL  = 5'h15;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int SACC_CLOCK_HZ   = 40000000;
    localparam int SACC_RATE_SPS   = 100000;
    localparam int SACC_CYCLES_PER_SAMPLE = SACC_CLOCK_HZ / SACC_RATE_SPS;
    localparam logic [4:0] SACC_SETTLE_CYCLES = 5'h02;
    // ****************************************************************
    // states
    // ****************************************************************
    typedef enum logic [2:0] {
        SACC_ACQUIRE   = 3'b000,
        SACC_OPEN_GND  = 3'b001,
        SACC_MOVE_GND  = 3'b010,
        SACC_SEARCH    = 3'b011,
        SACC_FINISH    = 3'b100
    } sacc_state_t;
endpackage

// [tb/sacc_control_tb.sv]
// self-checking bench of the conversion control and serial readout
`timescale 1ns/1ps
`default_nettype none
module sacc_control_tb;
    import sacc_pkg::*;
    logic        i_clock = 1'b0;
    logic        i_reset = 1'b1;
    logic        over    = 1'b0;
    logic        under   = 1'b0;
    logic [15:0] analog  = 16'h0000;
    wire logic   sel_n, bclk, sw_p, sw_n, on_in, powered, busy, dout, doe;
    wire logic [15:0] trial, result;
    int          n_fail  = 0;
    int          n_checks = 0;
    always #12.5 i_clock = ~i_clock;
    sacc_control sacc_control_i (.i_clock(i_clock), .i_reset(i_reset), .i_select_n(sel_n),
        .i_serial_bit_clock(bclk), .i_comp_high(trial <= analog), .i_over_range(over),
        .i_under_range(under), .o_positive_array_ground_switch(sw_p),
        .o_negative_array_ground_switch(sw_n), .o_arrays_on_inputs(on_in),
        .o_trial_bits(trial), .o_powered(powered), .o_busy(busy), .o_result(result),
        .o_data_out(dout), .o_data_oe(doe));
    sacc_host_model sacc_host_model_i (.o_select_n(sel_n), .o_bit_clock(bclk),
        .i_data(doe ? dout : ~dout), .i_data_oe(doe));
    // ****************************************************************
    // checks and scenarios
    // ****************************************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic watch_phases();
        int k;
        for (k = 0; k < 100 && busy !== 1'b1; k++) begin @(posedge i_clock); #1; end
        check("busy", {15'h0, busy}, 16'h0001);
        check("powered", {15'h0, powered}, 16'h0001);
        check("switches open", {14'h0, sw_p, sw_n}, 16'h0000);
        check("arrays on inputs", {15'h0, on_in}, 16'h0001);
        for (k = 0; k < 50 && on_in !== 1'b0; k++) begin @(posedge i_clock); #1; end
        check("switches after move", {14'h0, sw_p, sw_n}, 16'h0000);
        for (k = 0; k < 50 && trial === 16'h0000; k++) begin @(posedge i_clock); #1; end
        check("first trial", trial, 16'h8000);
        for (k = 0; k < 50 && busy !== 1'b0; k++) begin @(posedge i_clock); #1; end
        repeat (2) @(posedge i_clock);
        #1;
        check("acquire state", {13'h0, sw_p, sw_n, on_in}, 16'h0007);
        check("powered down", {15'h0, powered}, 16'h0000);
    endtask
    task automatic convert(input logic [15:0] v, input logic ov, input logic un,
                           input logic [15:0] exp);
        logic [15:0] w;
        logic        ok;
        @(posedge i_clock);
        #2;
        analog = v;
        over = ov;
        under = un;
        fork
            sacc_host_model_i.frame(w, ok);
            watch_phases();
        join
        check("serial word", w, exp);
        check("result", result, exp);
        check("lead bits", {15'h0, ok}, 16'h0001);
        repeat (6) @(posedge i_clock);
        #2;
        check("oe idle", {15'h0, doe}, 16'h0000);
    endtask
    task automatic reset_values();
        check("reset state", {11'h0, sw_p, sw_n, on_in, doe, busy}, 16'h001C);
        check("reset result", result, 16'h0000);
    endtask
    task automatic codes_scan();
        logic [15:0] codes [6] = '{16'h8000, 16'h0000, 16'hFFFF, 16'h7FFF, 16'h8001, 16'h0001};
        foreach (codes[i]) convert(codes[i], 1'b0, 1'b0, codes[i]);
    endtask
    task automatic range_clamp();
        convert(16'h1234, 1'b1, 1'b0, SACC_CODE_ONES);
        convert(16'h5678, 1'b0, 1'b1, SACC_CODE_ZERO);
        convert(16'h4321, 1'b1, 1'b1, SACC_CODE_ONES);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_clock);
        #2;
        i_reset = 1'b0;
        repeat (4) @(posedge i_clock);
        #2;
        reset_values();
        codes_scan();
        range_clamp();
        wrap_up();
    end
    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end
endmodule
`default_nettype wire

// [tb/sacc_host_model.sv]
// host serial controller model driving select and bit clock
`timescale 1ns/1ps
`default_nettype none
module sacc_host_model (
    output logic      o_select_n,  // host select, active low
    output logic      o_bit_clock, // host bit clock, idle high
    input  wire logic i_data,      // device serial data
    input  wire logic i_data_oe    // device data enable
);
    // ****************************************************************
    // one frame: select low, 21 falls, sample late in each high phase
    // ****************************************************************
    initial begin
        o_select_n = 1'b1;
        o_bit_clock = 1'b1;
    end
    task automatic frame(output logic [15:0] word, output logic lead_ok);
        word = 16'h0000;
        lead_ok = 1'b1;
        o_select_n = 1'b0;
        #300;
        for (int n = 1; n <= 21; n++) begin
            o_bit_clock = 1'b0;
            #100;
            o_bit_clock = 1'b1;
            #90;
            if (n < 5 && i_data_oe !== 1'b0) lead_ok = 1'b0;
            if (n >= 5 && i_data_oe !== 1'b1) lead_ok = 1'b0;
            if (n == 5 && i_data !== 1'b0) lead_ok = 1'b0;
            if (n > 5) word = {word[14:0], i_data};
            #10;
        end
        o_select_n = 1'b1;
    endtask
endmodule
`default_nettype wire
